// ===== verilog/sbi_params.svh
`ifndef SBI_PARAMS_SVH
`define SBI_PARAMS_SVH
`define SBI_ADDR_CTRL 12'h000
`define SBI_ADDR_STEP 12'h004
`define SBI_ADDR_MDC 12'h008
`define SBI_ADDR_BLANK 12'h00c
`define SBI_ADDR_ACC 12'h010
`define SBI_ADDR_STAT 12'h014
`define SBI_ADDR_SAMPLE 12'h018
`define SBI_CTRL_MCEN 0
`define SBI_CTRL_ITG 1
`define SBI_CTRL_POL 2
`define SBI_CTRL_PRE 3
`define SBI_CTRL_DIR 4
`define SBI_CTRL_BLNK 5
`define SBI_STAT_OVF 0
`define SBI_STAT_ZERO 1
`define SBI_PRE_LO 10'h03f
`define SBI_PRE_HI 10'h1ff
`define SBI_CTRL_RST 6'h00
`endif

// ===== verilog/sbi_pkg.sv
package sbi_pkg;
  typedef enum logic [1:0] {
    SBI_IDLE,
    SBI_BLANKING,
    SBI_INTEG
  } sbi_state_t;
  typedef logic [1:0] sbi_phase_t;
endpackage : sbi_pkg

// ===== verilog/sbi_sync.sv
`timescale 1ns/10ps
module sbi_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;

  always_comb begin
    s1_d = en_i ? d_i : s1_q;
    s2_d = en_i ? s1_q : s2_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q_o = s2_q;
endmodule : sbi_sync

// ===== verilog/sbi_stepper.sv
`timescale 1ns/10ps
`include "sbi_params.svh"
module sbi_stepper #(
  parameter int ACC_W = 16,
  parameter int MDC_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coil_a_plus_pin_i,
  input wire logic coil_a_minus_pin_i,
  input wire logic coil_b_plus_pin_i,
  input wire logic coil_b_minus_pin_i,
  output logic coil_a_plus_pin_o,
  output logic coil_a_minus_pin_o,
  output logic coil_b_plus_pin_o,
  output logic coil_b_minus_pin_o,
  output logic coil_a_plus_pin_oe_o,
  output logic coil_a_minus_pin_oe_o,
  output logic coil_b_plus_pin_oe_o,
  output logic coil_b_minus_pin_oe_o,
  output logic recirculate_o
);
  logic [5:0] ctrl_q;
  logic [5:0] ctrl_d;
  logic [MDC_W-1:0] mdc_q;
  logic [MDC_W-1:0] mdc_d;
  logic [MDC_W-1:0] half_q;
  logic [MDC_W-1:0] half_d;
  logic [MDC_W-1:0] blank_len_q;
  logic [MDC_W-1:0] blank_len_d;
  logic [MDC_W-1:0] blank_cnt_q;
  logic [MDC_W-1:0] blank_cnt_d;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_d;
  logic ovf_q;
  logic ovf_d;
  logic ocan_arm_q;
  logic ocan_arm_d;
  logic ocan_swap_q;
  logic ocan_swap_d;
  logic [9:0] pre_q;
  logic [9:0] pre_d;
  sbi_pkg::sbi_phase_t phase_q;
  sbi_pkg::sbi_phase_t phase_d;
  sbi_pkg::sbi_state_t st_q;
  sbi_pkg::sbi_state_t st_d;
  logic [3:0] pins_s;
  logic tick;
  logic wr;
  logic rd_ok;
  logic coil_b_idle;
  logic in_p;
  logic in_m;
  logic signed [1:0] sample;
  logic signed [ACC_W:0] acc_sum;
  logic [9:0] pre_lim;

  // Coil pins are read back through two flops since they come from the pads.
  sbi_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(clk_en_i),
    .d_i({coil_b_minus_pin_i, coil_b_plus_pin_i, coil_a_minus_pin_i, coil_a_plus_pin_i}),
    .q_o(pins_s)
  );

  assign pready = 1'b1;
  assign wr = psel && penable && pwrite && clk_en_i;

  always_comb begin
    rd_ok = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      `SBI_ADDR_CTRL: prdata = {26'h0, ctrl_q};
      `SBI_ADDR_STEP: prdata = {30'h0, phase_q};
      `SBI_ADDR_MDC: prdata = {{(32-MDC_W){1'b0}}, mdc_q};
      `SBI_ADDR_BLANK: prdata = {{(32-MDC_W){1'b0}}, blank_len_q};
      `SBI_ADDR_ACC: prdata = {{(32-ACC_W){acc_q[ACC_W-1]}}, acc_q};
      `SBI_ADDR_STAT: prdata = {30'h0, (mdc_q == '0), ovf_q};
      `SBI_ADDR_SAMPLE: prdata = {28'h0, pins_s};
      default: rd_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !rd_ok;

  // A single divider; choosing 64 or 512 only changes its wrap point.
  assign pre_lim = ctrl_q[`SBI_CTRL_PRE] ? `SBI_PRE_HI : `SBI_PRE_LO;
  assign tick = ctrl_q[`SBI_CTRL_MCEN] && (pre_q == pre_lim);

  // Coil B is the undriven coil in even phases, coil A in odd phases.
  assign coil_b_idle = ~phase_q[0];
  always_comb begin
    in_p = coil_b_idle ? pins_s[2] : pins_s[0];
    in_m = coil_b_idle ? pins_s[3] : pins_s[1];
    if (ctrl_q[`SBI_CTRL_POL] ^ ocan_swap_q) begin
      in_p = coil_b_idle ? pins_s[3] : pins_s[1];
      in_m = coil_b_idle ? pins_s[2] : pins_s[0];
    end
    sample = 2'sd0;
    if (in_p && !in_m) begin
      sample = 2'sd1;
    end else if (!in_p && in_m) begin
      sample = -2'sd1;
    end
    acc_sum = {acc_q[ACC_W-1], acc_q} + {{(ACC_W-1){sample[1]}}, sample};
  end

  always_comb begin
    ctrl_d = ctrl_q;
    mdc_d = mdc_q;
    half_d = half_q;
    blank_len_d = blank_len_q;
    blank_cnt_d = blank_cnt_q;
    acc_d = acc_q;
    ovf_d = ovf_q;
    ocan_arm_d = ocan_arm_q;
    ocan_swap_d = ocan_swap_q;
    phase_d = phase_q;
    st_d = st_q;
    pre_d = (ctrl_q[`SBI_CTRL_MCEN] && pre_q != pre_lim) ? pre_q + 10'h001 : 10'h000;
    if (tick && mdc_q != '0) begin
      mdc_d = mdc_q - 1'b1;
      if (mdc_q - 1'b1 == half_q && ocan_arm_q) begin
        ocan_swap_d = 1'b1;
      end
    end
    case (st_q)
      sbi_pkg::SBI_IDLE: begin
        ocan_swap_d = 1'b0;
      end
      sbi_pkg::SBI_BLANKING: begin
        if (tick) begin
          blank_cnt_d = blank_cnt_q - 1'b1;
        end
        if (blank_cnt_q == '0) begin
          st_d = sbi_pkg::SBI_INTEG;
        end
      end
      sbi_pkg::SBI_INTEG: begin
        if (tick) begin
          acc_d = acc_sum[ACC_W-1:0];
          if (acc_sum[ACC_W] != acc_sum[ACC_W-1]) begin
            ovf_d = 1'b1;
            acc_d = acc_q; // Saturation by holding keeps the sign usable.
          end
        end
      end
      default: st_d = sbi_pkg::SBI_IDLE;
    endcase
    if (!ctrl_q[`SBI_CTRL_ITG]) begin
      st_d = sbi_pkg::SBI_IDLE;
    end
    if (wr) begin
      case (paddr)
        `SBI_ADDR_CTRL: begin
          ctrl_d = pwdata[5:0];
          if (pwdata[`SBI_CTRL_ITG] && !ctrl_q[`SBI_CTRL_ITG]) begin
            // Offset cancellation needs MCEN set and a count loaded first.
            ocan_arm_d = ctrl_q[`SBI_CTRL_MCEN] && mdc_q != '0;
            ocan_swap_d = 1'b0;
            blank_cnt_d = blank_len_q;
            st_d = pwdata[`SBI_CTRL_BLNK] ? sbi_pkg::SBI_BLANKING : sbi_pkg::SBI_INTEG;
          end
        end
        `SBI_ADDR_STEP: begin
          // Only a step write advances the phase; direction picks the order.
          phase_d = ctrl_q[`SBI_CTRL_DIR] ? phase_q - 2'd1 : phase_q + 2'd1;
        end
        `SBI_ADDR_MDC: begin
          mdc_d = pwdata[MDC_W-1:0];
          half_d = {1'b0, pwdata[MDC_W-1:1]};
          ocan_arm_d = 1'b0;
        end
        `SBI_ADDR_BLANK: blank_len_d = pwdata[MDC_W-1:0];
        `SBI_ADDR_ACC: acc_d = pwdata[ACC_W-1:0];
        `SBI_ADDR_STAT: begin
          if (pwdata[`SBI_STAT_OVF] && !(ovf_d && !ovf_q)) begin
            ovf_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_q <= `SBI_CTRL_RST;
      mdc_q <= '0;
      half_q <= '0;
      blank_len_q <= '0;
      blank_cnt_q <= '0;
      acc_q <= '0;
      ovf_q <= 1'b0;
      ocan_arm_q <= 1'b0;
      ocan_swap_q <= 1'b0;
      pre_q <= 10'h000;
      phase_q <= 2'd0;
      st_q <= sbi_pkg::SBI_IDLE;
    end else if (clk_en_i) begin
      ctrl_q <= ctrl_d;
      mdc_q <= mdc_d;
      half_q <= half_d;
      blank_len_q <= blank_len_d;
      blank_cnt_q <= blank_cnt_d;
      acc_q <= acc_d;
      ovf_q <= ovf_d;
      ocan_arm_q <= ocan_arm_d;
      ocan_swap_q <= ocan_swap_d;
      pre_q <= pre_d;
      phase_q <= phase_d;
      st_q <= st_d;
    end
  end

  // Phase 0: A+, 1: B+, 2: A-, 3: B-. The idle coil has both pins low.
  always_comb begin
    coil_a_plus_pin_o = (phase_q == 2'd0);
    coil_a_minus_pin_o = (phase_q == 2'd2);
    coil_b_plus_pin_o = (phase_q == 2'd1);
    coil_b_minus_pin_o = (phase_q == 2'd3);
    coil_a_plus_pin_oe_o = 1'b1;
    coil_a_minus_pin_oe_o = 1'b1;
    coil_b_plus_pin_oe_o = 1'b1;
    coil_b_minus_pin_oe_o = 1'b1;
    // Releasing the idle coil lets its back EMF appear across the pins.
    if (st_q == sbi_pkg::SBI_INTEG) begin
      coil_a_plus_pin_oe_o = coil_b_idle;
      coil_a_minus_pin_oe_o = coil_b_idle;
      coil_b_plus_pin_oe_o = !coil_b_idle;
      coil_b_minus_pin_oe_o = !coil_b_idle;
    end
  end
  assign recirculate_o = (st_q == sbi_pkg::SBI_BLANKING);
endmodule : sbi_stepper

// ===== test/sbi_motor.sv
`timescale 1ns/10ps
// Two coils seen from the pads: a released pin shows the coil's induced
// level, never the last driven value, so a stale readback cannot pass.
module sbi_motor (
  input wire logic [3:0] drv_i,
  input wire logic [3:0] oe_i,
  input wire logic emf_i,
  output logic [3:0] pin_o
);
  assign pin_o = (oe_i & drv_i) | (~oe_i & {~emf_i, ~emf_i, emf_i, emf_i});
endmodule : sbi_motor

// ===== test/sbi_stepper_asserts.sv
`timescale 1ns/10ps
`include "sbi_params.svh"
module sbi_stepper_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic coil_a_plus_pin_o,
  input wire logic coil_a_minus_pin_o,
  input wire logic coil_b_plus_pin_o,
  input wire logic coil_b_minus_pin_o,
  input wire logic coil_a_plus_pin_oe_o,
  input wire logic coil_a_minus_pin_oe_o,
  input wire logic coil_b_plus_pin_oe_o,
  input wire logic coil_b_minus_pin_oe_o
);
  logic [3:0] drv, oe, drv_q;
  logic ovf_q, rd;
  assign drv = {coil_b_minus_pin_o, coil_a_minus_pin_o, coil_b_plus_pin_o, coil_a_plus_pin_o};
  assign oe = {coil_b_minus_pin_oe_o, coil_a_minus_pin_oe_o, coil_b_plus_pin_oe_o,
    coil_a_plus_pin_oe_o};
  assign rd = psel && penable && !pwrite;
  // Remembers an overflow that software has seen, so a silent clear is caught.
  always_ff @(posedge clk_i) begin
    drv_q <= drv;
    if (!rst_b_i) ovf_q <= 1'b0;
    else if (rd && paddr == `SBI_ADDR_STAT && prdata[0]) ovf_q <= 1'b1;
    else if (psel && penable && pwrite && paddr == `SBI_ADDR_STAT && pwdata[0]) ovf_q <= 1'b0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_one; $onehot(drv); endproperty
  a_one: assert property (p_one) else $error("coil drive not one-hot");
  property p_order; $past(rst_b_i) && drv != drv_q |->
    drv == {drv_q[2:0], drv_q[3]} || drv == {drv_q[0], drv_q[3:1]}; endproperty
  a_order: assert property (p_order) else $error("step out of order");
  property p_pair; oe[0] == oe[2] && oe[1] == oe[3] && (oe[0] || oe[1]); endproperty
  a_pair: assert property (p_pair) else $error("bad coil release");
  property p_other; (oe[0] || drv[1] ^ drv[3]) && (oe[1] || drv[0] ^ drv[2]); endproperty
  a_other: assert property (p_other) else $error("driven coil idle");
  property p_sign; rd && paddr == `SBI_ADDR_ACC |-> prdata[31:16] == {16{prdata[15]}};
  endproperty
  a_sign: assert property (p_sign) else $error("accumulator not sign extended");
  property p_ovf; rd && paddr == `SBI_ADDR_STAT && ovf_q |-> prdata[0]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag lost");
  property p_err; psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `SBI_ADDR_SAMPLE); endproperty
  a_err: assert property (p_err) else $error("bad slave error");
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
endmodule : sbi_stepper_asserts

// ===== test/sbi_stepper_tb.sv
`timescale 1ns/10ps
`include "sbi_params.svh"
module sbi_stepper_tb;
  logic clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, recirc;
  logic en = 1'b1;
  logic [3:0] o, oe, pin;
  int n_mismatch = 0, n_checks = 0, n, cyc;
  time t0;
  logic [31:0] exp_q[$], msk_q[$];
  always #50 clk_i = ~clk_i;
  sbi_stepper i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coil_a_plus_pin_i(pin[0]),
    .coil_a_minus_pin_i(pin[2]), .coil_b_plus_pin_i(pin[1]), .coil_b_minus_pin_i(pin[3]),
    .coil_a_plus_pin_o(o[0]), .coil_a_minus_pin_o(o[2]), .coil_b_plus_pin_o(o[1]),
    .coil_b_minus_pin_o(o[3]), .coil_a_plus_pin_oe_o(oe[0]), .coil_a_minus_pin_oe_o(oe[2]),
    .coil_b_plus_pin_oe_o(oe[1]), .coil_b_minus_pin_oe_o(oe[3]), .recirculate_o(recirc));
  sbi_motor i_mot (.drv_i(o), .oe_i(oe), .emf_i(1'b1), .pin_o(pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Stopping the counter first keeps a stray tick from eating the fresh count.
  task automatic meas(input int cnt, input logic [31:0] ctrl, input int div);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h0);
    apb(1'b1, `SBI_ADDR_MDC, cnt);
    apb(1'b1, `SBI_ADDR_CTRL, ctrl);
    t0 = $time;
    do rd(`SBI_ADDR_STAT, 32'h0, 32'h0); while (rdata[1] !== 1'b1);
    cyc = ($time - t0) / 100;
    check(cyc > (cnt - 1) * div && cyc <= cnt * div + 8, 32'h1);
  endtask : meas
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      check(prdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    void'($urandom(62198));
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(`SBI_ADDR_ACC, 32'h0, 32'hffffffff);
    rd(12'h01c, 32'h0, 32'hffffffff);
    for (int k = 1; k <= 4; k++) begin
      apb(1'b1, `SBI_ADDR_STEP, 32'h0);
      @(negedge clk_i);
      check({28'h0, o}, 32'h1 << (k % 4));
    end
    apb(1'b1, `SBI_ADDR_CTRL, 32'h10);
    apb(1'b1, `SBI_ADDR_STEP, 32'h0);
    @(negedge clk_i);
    check({28'h0, o}, 32'h8);
    check({28'h0, oe}, 32'hf);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h0);
    apb(1'b1, `SBI_ADDR_STEP, 32'h0);
    $display("step test done");
    n = 8 + $urandom_range(7);
    meas(n, 32'h1, 64);
    meas(2, 32'h9, 512);
    $display("prescale test done");
    apb(1'b1, `SBI_ADDR_CTRL, 32'h2);
    apb(1'b1, `SBI_ADDR_MDC, 32'hffff);
    apb(1'b1, `SBI_ADDR_ACC, 32'h0);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h3);
    repeat (1280) @(posedge clk_i);
    rd(`SBI_ADDR_ACC, 32'h0, 32'hffff8000);
    check(rdata >= 18 && rdata <= 21, 32'h1);
    check({28'h0, oe}, 32'h5);
    apb(1'b1, `SBI_ADDR_ACC, 32'h0);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h7);
    repeat (1280) @(posedge clk_i);
    rd(`SBI_ADDR_ACC, 32'hffff8000, 32'hffff8000);
    check(rdata[15:0] >= 16'hffeb && rdata[15:0] <= 16'hffee, 32'h1);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h3);
    apb(1'b1, `SBI_ADDR_ACC, 32'h7ffd);
    repeat (384) @(posedge clk_i);
    rd(`SBI_ADDR_STAT, 32'h1, 32'h1);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h1);
    apb(1'b1, `SBI_ADDR_ACC, 32'h1234);
    repeat (200) @(posedge clk_i);
    rd(`SBI_ADDR_STAT, 32'h1, 32'h1);
    rd(`SBI_ADDR_ACC, 32'h1234, 32'hffffffff);
    apb(1'b1, `SBI_ADDR_STAT, 32'h1);
    rd(`SBI_ADDR_STAT, 32'h0, 32'h1);
    en <= 1'b0;
    apb(1'b1, `SBI_ADDR_ACC, 32'h55);
    en <= 1'b1;
    rd(`SBI_ADDR_ACC, 32'h1234, 32'hffffffff);
    apb(1'b1, `SBI_ADDR_MDC, 32'h28);
    apb(1'b1, `SBI_ADDR_ACC, 32'h0);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h3);
    do rd(`SBI_ADDR_STAT, 32'h0, 32'h0); while (rdata[1] !== 1'b1);
    rd(`SBI_ADDR_ACC, 32'h0, 32'hffffffff);
    $display("integration test done");
    apb(1'b1, `SBI_ADDR_BLANK, 32'h3);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h21);
    apb(1'b1, `SBI_ADDR_CTRL, 32'h23);
    for (cyc = 0; recirc !== 1'b1 && cyc < 100; cyc++) @(posedge clk_i);
    for (cyc = 0; recirc === 1'b1 && cyc < 2000; cyc++) @(posedge clk_i);
    check(cyc > 128 && cyc <= 200, 32'h1);
    $display("blanking test done");
    report_and_stop();
  end
endmodule : sbi_stepper_tb
bind sbi_stepper sbi_stepper_asserts i_chk (.*);
